/* File: ipse_map.svh */
`ifndef IPSE_MAP_SVH
`define IPSE_MAP_SVH
// Register addresses (12-bit special function space)
`define IPSE_ADDR_PRIO1 12'hf9f
`define IPSE_ADDR_PRIO2 12'hfa2
`define IPSE_ADDR_PRIO3 12'hfa5
`define IPSE_ADDR_RCAUSE 12'hfd0
`define IPSE_ADDR_MAIN 12'hff2
`define IPSE_ADDR_CTL2 12'hff1
`define IPSE_ADDR_CTL3 12'hff0
`define IPSE_ADDR_FLAGS 12'hf9e
`define IPSE_ADDR_ENABLES 12'hf9d
`define IPSE_ADDR_CORE 12'hf9c
// Reset values
`define IPSE_PRIO_RST 8'hff
`define IPSE_RCAUSE_RST 8'h3c
`define IPSE_ZERO8 8'h00
`define IPSE_CTL3_RST 8'hc0
// Reset-cause register fields
`define IPSE_RC_PRIO_ON 7
`define IPSE_RC_UNUSED 6
`define IPSE_RC_MISMATCH 5
`define IPSE_RC_RESET_INSN 4
`define IPSE_RC_WDT 3
`define IPSE_RC_PDOWN 2
`define IPSE_RC_POR 1
`define IPSE_RC_BOR 0
// Main control fields
`define IPSE_MC_GHIGH 7
`define IPSE_MC_GLOW 6
`define IPSE_MC_T0_EN 5
`define IPSE_MC_X0_EN 4
`define IPSE_MC_PB_EN 3
`define IPSE_MC_T0_FLAG 2
`define IPSE_MC_X0_FLAG 1
`define IPSE_MC_PB_FLAG 0
// Control two fields
`define IPSE_C2_EDGE0 6
`define IPSE_C2_EDGE1 5
`define IPSE_C2_EDGE2 4
`define IPSE_C2_EDGE3 3
`define IPSE_C2_T0_PRIO 2
`define IPSE_C2_X3_PRIO 1
`define IPSE_C2_PB_PRIO 0
// Control three fields
`define IPSE_C3_X2_PRIO 7
`define IPSE_C3_X1_PRIO 6
`define IPSE_C3_X3_EN 5
`define IPSE_C3_X2_EN 4
`define IPSE_C3_X1_EN 3
`define IPSE_C3_X3_FLAG 2
`define IPSE_C3_X2_FLAG 1
`define IPSE_C3_X1_FLAG 0
// Core control fields (own register)
`define IPSE_CR_PERIPH_EN 0
`define IPSE_CR_T0_16BIT 1
// Unimplemented parallel port priority bit
`define IPSE_PP_PRIO_BIT 7
`define IPSE_T0_MAX8 8'hff
`define IPSE_T0_MAX16 16'hffff
`endif

/* File: ipse_pkg.sv */
package ipse_pkg;
  typedef enum logic [1:0] {
    IPSE_RUN,
    IPSE_SLEEP,
    IPSE_DEEP
  } ipse_pwr_e;
  // Snapshot of core context saved on interrupt entry
  typedef struct packed {
    logic [7:0] work;
    logic [7:0] status;
    logic [7:0] bank;
  } ipse_ctx_s;
  typedef struct packed {
    logic [7:0] prio1;
    logic [7:0] prio2;
    logic [7:0] prio3;
    logic [7:0] rcause;
    logic [7:0] main_ctl;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic [7:0] core_ctl;
    logic [3:0] pin_prev;
    logic [3:0] pb_prev;
    logic [15:0] t0_prev;
    ipse_pwr_e pwr;
    logic wake;
    logic por_vec;
    logic vec_high;
    logic vec_low;
    logic [20:0] ret_pc;
    ipse_ctx_s shadow;
    logic [7:0] rdata;
  } ipse_state_s;
endpackage

/* File: ipse_ctrl.sv */
`timescale 1ns/1ps
`include "ipse_map.svh"
// How it works
// - One priority bit per source but pin zero, 1 high
// - Priority bits matter only when levels on
// - Bit 7 enables levels; 0 single level
// - Pins edge triggered; select 1 rising
// - Valid pin edge sets its flag
// - Cleared enable suppresses pin request
// - Enabled pin interrupts wake Sleep
// - Vector only when global enables allow
// - Deep Sleep wakes on pin zero, reset
// - Pin 1,2,3 priorities from writable control bits
// - Pin zero always high priority
// - Eight-bit timer wrap sets overflow flag
// - Sixteen-bit pair wrap sets overflow flag
// - Timer enable main bit 5, priority
// - Port B high nibble change flag
// - Taking interrupt saves PC and shadow
// - Reset-cause flags readable, bit 6 zero
// - Parallel port priority bit unimplemented in small package
// - Single level needs peripheral global enable
module ipse_ctrl #(
  parameter int NPER = 24,
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [3:0] EXT_PIN,
  input wire logic [7:4] PORTB_IN,
  input wire logic [15:0] T0_COUNT,
  input wire logic [NPER-1:0] PERIPH_FLAG,
  input wire logic [NPER-1:0] PERIPH_EN,
  input wire logic SLEEP_REQ,
  input wire logic DEEP_REQ,
  input wire logic [5:0] CAUSE_SET,
  input wire logic TAKE,
  input wire logic [20:0] CORE_PC,
  input wire ipse_pkg::ipse_ctx_s CORE_CTX,
  output logic IRQ_HIGH,
  output logic IRQ_LOW,
  output logic WAKE,
  output logic POR_VECTOR,
  output logic [20:0] STACK_PC,
  output ipse_pkg::ipse_ctx_s SHADOW
);
  ipse_pkg::ipse_state_s s_reg;
  ipse_pkg::ipse_state_s s_next;

  logic [3:0] pin_edge;
  logic [3:0] pin_prio;
  logic [3:0] pin_en;
  logic [3:0] pin_flag;
  logic [NPER-1:0] per_prio;
  logic levels_on;
  logic any_high;
  logic any_low;
  logic any_pin;
  logic t0_wrap;
  logic pb_change;
  logic [7:0] prio1_mask;

  // Edge test picks rising or falling per select bit
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  // Hardware set beats software clear on every flag
  function automatic logic [7:0] flag_write(input logic [7:0] old,
      input logic [7:0] wdat, input logic [7:0] setv);
    flag_write = wdat | setv | (old & 8'h00);
  endfunction

  assign levels_on = s_reg.rcause[`IPSE_RC_PRIO_ON];
  // Narrow package hides the parallel port priority bit
  assign prio1_mask = SMALL_PKG ? 8'h7f : 8'hff;

  // Per-pin views of scattered control bits
  always_comb begin
    pin_en = {s_reg.ctl3[`IPSE_C3_X3_EN], s_reg.ctl3[`IPSE_C3_X2_EN],
              s_reg.ctl3[`IPSE_C3_X1_EN], s_reg.main_ctl[`IPSE_MC_X0_EN]};
    pin_flag = {s_reg.ctl3[`IPSE_C3_X3_FLAG], s_reg.ctl3[`IPSE_C3_X2_FLAG],
                s_reg.ctl3[`IPSE_C3_X1_FLAG],
                s_reg.main_ctl[`IPSE_MC_X0_FLAG]};
    // Pin zero has no priority bit: always high
    pin_prio = {s_reg.ctl2[`IPSE_C2_X3_PRIO], s_reg.ctl3[`IPSE_C3_X2_PRIO],
                s_reg.ctl3[`IPSE_C3_X1_PRIO], 1'b1};
    per_prio = NPER'({s_reg.prio3, s_reg.prio2, s_reg.prio1 & prio1_mask});
    for (int i = 0; i < 4; i++) begin
      pin_edge[i] = edge_hit(s_reg.pin_prev[i], EXT_PIN[i],
                    s_reg.ctl2[`IPSE_C2_EDGE0 - i]);
    end
  end

  // Timer wrap seen as max value followed by zero
  assign t0_wrap = s_reg.core_ctl[`IPSE_CR_T0_16BIT] ?
    (s_reg.t0_prev == `IPSE_T0_MAX16 && T0_COUNT == 16'h0000) :
    (s_reg.t0_prev[7:0] == `IPSE_T0_MAX8 &&
     T0_COUNT[7:0] == 8'h00);
  assign pb_change = PORTB_IN != s_reg.pb_prev;

  // Request sort: flag and enable, then priority routing
  always_comb begin
    logic [4:0] core_hi;
    logic [4:0] core_req;
    logic per_hi_any;
    logic per_lo_any;
    core_req = {s_reg.main_ctl[`IPSE_MC_T0_FLAG] &
                s_reg.main_ctl[`IPSE_MC_T0_EN],
                s_reg.main_ctl[`IPSE_MC_PB_FLAG] &
                s_reg.main_ctl[`IPSE_MC_PB_EN],
                pin_flag[3:1] & pin_en[3:1]};
    core_hi = {s_reg.ctl2[`IPSE_C2_T0_PRIO], s_reg.ctl2[`IPSE_C2_PB_PRIO],
               pin_prio[3:1]};
    per_hi_any = |(PERIPH_FLAG & PERIPH_EN & per_prio);
    per_lo_any = |(PERIPH_FLAG & PERIPH_EN & ~per_prio);
    any_pin = |(pin_flag & pin_en);
    if (levels_on) begin
      any_high = (|(core_req & core_hi)) || (pin_flag[0] && pin_en[0]) ||
                 per_hi_any;
      any_low = (|(core_req & ~core_hi)) || per_lo_any;
    end else begin
      any_high = (|core_req) || (pin_flag[0] && pin_en[0]) ||
        ((per_hi_any || per_lo_any) &&
         s_reg.core_ctl[`IPSE_CR_PERIPH_EN]);
      any_low = 1'b0;
    end
  end

  // Next-state logic: bus, flags, power and vectoring
  always_comb begin
    logic [7:0] mset;
    logic [7:0] c3set;
    logic ghigh;
    logic glow;
    mset = `IPSE_ZERO8;
    c3set = `IPSE_ZERO8;
    ghigh = s_reg.main_ctl[`IPSE_MC_GHIGH];
    glow = s_reg.main_ctl[`IPSE_MC_GLOW];
    s_next = s_reg;
    s_next.pin_prev = EXT_PIN;
    s_next.pb_prev = PORTB_IN;
    s_next.t0_prev = T0_COUNT;
    s_next.rdata = `IPSE_ZERO8;
    mset[`IPSE_MC_X0_FLAG] = pin_edge[0];
    mset[`IPSE_MC_T0_FLAG] = t0_wrap;
    mset[`IPSE_MC_PB_FLAG] = pb_change;
    c3set[`IPSE_C3_X1_FLAG] = pin_edge[1];
    c3set[`IPSE_C3_X2_FLAG] = pin_edge[2];
    c3set[`IPSE_C3_X3_FLAG] = pin_edge[3];
    s_next.main_ctl = s_reg.main_ctl | mset;
    s_next.ctl3 = s_reg.ctl3 | c3set;
    s_next.rcause = s_reg.rcause | {2'b00, CAUSE_SET};
    if (WR) begin
      unique case (ADDR)
        `IPSE_ADDR_PRIO1: s_next.prio1 = WDATA & prio1_mask;
        `IPSE_ADDR_PRIO2: s_next.prio2 = WDATA;
        `IPSE_ADDR_PRIO3: s_next.prio3 = WDATA;
        `IPSE_ADDR_RCAUSE: begin
          // Power flags are read only; set wins over clear
          s_next.rcause = {WDATA[7], 1'b0, WDATA[5:4],
                           s_reg.rcause[3:2], WDATA[1:0]} |
                          {2'b00, CAUSE_SET};
        end
        `IPSE_ADDR_MAIN: s_next.main_ctl = flag_write(s_reg.main_ctl,
                                           WDATA, mset);
        `IPSE_ADDR_CTL2: s_next.ctl2 = WDATA;
        `IPSE_ADDR_CTL3: s_next.ctl3 = flag_write(s_reg.ctl3, WDATA, c3set);
        `IPSE_ADDR_CORE: s_next.core_ctl = WDATA;
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        `IPSE_ADDR_PRIO1: s_next.rdata = s_reg.prio1;
        `IPSE_ADDR_PRIO2: s_next.rdata = s_reg.prio2;
        `IPSE_ADDR_PRIO3: s_next.rdata = s_reg.prio3;
        `IPSE_ADDR_RCAUSE: s_next.rdata = s_reg.rcause;
        `IPSE_ADDR_MAIN: s_next.rdata = s_reg.main_ctl;
        `IPSE_ADDR_CTL2: s_next.rdata = s_reg.ctl2;
        `IPSE_ADDR_CTL3: s_next.rdata = s_reg.ctl3;
        `IPSE_ADDR_CORE: s_next.rdata = s_reg.core_ctl;
        `IPSE_ADDR_FLAGS: s_next.rdata = {6'h00, any_low, any_high};
        default: s_next.rdata = `IPSE_ZERO8;
      endcase
    end
    s_next.wake = 1'b0;
    s_next.por_vec = 1'b0;
    // Power state: Sleep wake uses enables and, in single level, the peripheral global enable; Deep wakes on a pin 0 edge alone
    unique case (s_reg.pwr)
      ipse_pkg::IPSE_RUN: begin
        if (DEEP_REQ) begin
          s_next.pwr = ipse_pkg::IPSE_DEEP;
        end else if (SLEEP_REQ) begin
          s_next.pwr = ipse_pkg::IPSE_SLEEP;
        end
      end
      ipse_pkg::IPSE_SLEEP: begin
        if (any_pin || any_high || any_low) begin
          s_next.pwr = ipse_pkg::IPSE_RUN;
          s_next.wake = 1'b1;
        end
      end
      ipse_pkg::IPSE_DEEP: begin
        if (pin_edge[0]) begin
          s_next.pwr = ipse_pkg::IPSE_RUN;
          s_next.wake = 1'b1;
          s_next.por_vec = 1'b1;
        end
      end
      default: s_next.pwr = ipse_pkg::IPSE_RUN;
    endcase
    // Vector only while running and globally enabled
    s_next.vec_high = (s_reg.pwr == ipse_pkg::IPSE_RUN) && any_high &&
                      ghigh;
    s_next.vec_low = (s_reg.pwr == ipse_pkg::IPSE_RUN) && any_low &&
                     ghigh && glow && levels_on;
    if (TAKE) begin
      s_next.ret_pc = CORE_PC;
      s_next.shadow = CORE_CTX;
    end
  end

  // Single register stage for all state
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      s_reg <= '0;
      s_reg.prio1 <= `IPSE_PRIO_RST & prio1_mask;
      s_reg.prio2 <= `IPSE_PRIO_RST;
      s_reg.prio3 <= `IPSE_PRIO_RST;
      s_reg.rcause <= `IPSE_RCAUSE_RST;
      s_reg.ctl2 <= `IPSE_PRIO_RST;
      s_reg.ctl3 <= `IPSE_CTL3_RST;
      s_reg.pwr <= ipse_pkg::IPSE_RUN;
      // History loads live levels: a pin held high is no edge
      s_reg.pin_prev <= EXT_PIN;
      s_reg.pb_prev <= PORTB_IN;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign IRQ_HIGH = s_reg.vec_high;
  assign IRQ_LOW = s_reg.vec_low;
  assign WAKE = s_reg.wake;
  assign POR_VECTOR = s_reg.por_vec;
  assign STACK_PC = s_reg.ret_pc;
  assign SHADOW = s_reg.shadow;

  // Checks
  property p_bit6_zero;
    @(posedge CORE_CLK) disable iff (!NRST)
      !s_reg.rcause[`IPSE_RC_UNUSED];
  endproperty
  a_bit6_zero: assert property (p_bit6_zero)
    else $error("unused reset-cause bit set");

  property p_edge_flag;
    @(posedge CORE_CLK) disable iff (!NRST)
      pin_edge[0] |=> s_reg.main_ctl[`IPSE_MC_X0_FLAG];
  endproperty
  a_edge_flag: assert property (p_edge_flag)
    else $error("pin edge did not set flag");

  property p_no_low_single;
    @(posedge CORE_CLK) disable iff (!NRST)
      !levels_on |=> !IRQ_LOW;
  endproperty
  a_no_low_single: assert property (p_no_low_single)
    else $error("low vector in single level mode");

  property p_take_save;
    @(posedge CORE_CLK) disable iff (!NRST)
      TAKE |=> (STACK_PC == $past(CORE_PC)) && (SHADOW == $past(CORE_CTX));
  endproperty
  a_take_save: assert property (p_take_save)
    else $error("context not saved");

  property p_high_gate;
    @(posedge CORE_CLK) disable iff (!NRST)
      IRQ_HIGH |-> $past(s_reg.main_ctl[`IPSE_MC_GHIGH]);
  endproperty
  a_high_gate: assert property (p_high_gate)
    else $error("high vector without global enable");

  property p_deep_por;
    @(posedge CORE_CLK) disable iff (!NRST)
      (s_reg.pwr == ipse_pkg::IPSE_DEEP && pin_edge[0]) |=>
        POR_VECTOR && WAKE;
  endproperty
  a_deep_por: assert property (p_deep_por)
    else $error("deep sleep wake missing");

  property p_t0_wrap8;
    @(posedge CORE_CLK) disable iff (!NRST)
      (!s_reg.core_ctl[`IPSE_CR_T0_16BIT] && t0_wrap) |=>
        s_reg.main_ctl[`IPSE_MC_T0_FLAG];
  endproperty
  a_t0_wrap8: assert property (p_t0_wrap8)
    else $error("timer wrap lost");

  property p_pp_prio;
    @(posedge CORE_CLK) disable iff (!NRST)
      SMALL_PKG |-> !s_reg.prio1[`IPSE_PP_PRIO_BIT];
  endproperty
  a_pp_prio: assert property (p_pp_prio)
    else $error("parallel port priority present");

  c_wake: cover property (@(posedge CORE_CLK) disable iff (!NRST) WAKE);
  c_low: cover property (@(posedge CORE_CLK) disable iff (!NRST) IRQ_LOW);
  c_take: cover property (@(posedge CORE_CLK) disable iff (!NRST)
                          IRQ_HIGH ##1 TAKE);
  c_deep: cover property (@(posedge CORE_CLK) disable iff (!NRST)
                          POR_VECTOR);
  c_wrap16: cover property (@(posedge CORE_CLK) disable iff (!NRST)
                            s_reg.core_ctl[`IPSE_CR_T0_16BIT] && t0_wrap);

  // Port B change seen from the raw input, not the helper
  property p_pb_flag;
    @(posedge CORE_CLK) disable iff (!NRST)
      (PORTB_IN != s_reg.pb_prev) |=> s_reg.main_ctl[`IPSE_MC_PB_FLAG];
  endproperty
  a_pb_flag: assert property (p_pb_flag)
    else $error("port change did not set flag");

  property p_t0_wrap16;
    @(posedge CORE_CLK) disable iff (!NRST)
      (s_reg.core_ctl[`IPSE_CR_T0_16BIT] &&
       s_reg.t0_prev == `IPSE_T0_MAX16 && T0_COUNT == 16'h0000) |=>
        s_reg.main_ctl[`IPSE_MC_T0_FLAG];
  endproperty
  a_t0_wrap16: assert property (p_t0_wrap16)
    else $error("sixteen bit timer wrap lost");

  // Pin 1 polarity checked apart from the shared edge function
  property p_pin1_rise;
    @(posedge CORE_CLK) disable iff (!NRST)
      (s_reg.ctl2[`IPSE_C2_EDGE1] && !s_reg.pin_prev[1] && EXT_PIN[1]) |=>
        s_reg.ctl3[`IPSE_C3_X1_FLAG];
  endproperty
  a_pin1_rise: assert property (p_pin1_rise)
    else $error("rising edge on pin one missed");

  property p_pin1_fall;
    @(posedge CORE_CLK) disable iff (!NRST)
      (!s_reg.ctl2[`IPSE_C2_EDGE1] && s_reg.pin_prev[1] && !EXT_PIN[1]) |=>
        s_reg.ctl3[`IPSE_C3_X1_FLAG];
  endproperty
  a_pin1_fall: assert property (p_pin1_fall)
    else $error("falling edge on pin one missed");

  property p_low_gate;
    @(posedge CORE_CLK) disable iff (!NRST)
      IRQ_LOW |-> $past(s_reg.main_ctl[`IPSE_MC_GLOW]) &&
        $past(s_reg.main_ctl[`IPSE_MC_GHIGH]);
  endproperty
  a_low_gate: assert property (p_low_gate)
    else $error("low vector without both global enables");

  // Power flags survive a software write
  property p_rc_ro;
    @(posedge CORE_CLK) disable iff (!NRST)
      (WR && ADDR == `IPSE_ADDR_RCAUSE) |=>
        s_reg.rcause[3:2] == ($past(s_reg.rcause[3:2]) |
                              $past(CAUSE_SET[3:2]));
  endproperty
  a_rc_ro: assert property (p_rc_ro)
    else $error("read only reset-cause bits written");

  property p_prio_on;
    @(posedge CORE_CLK) disable iff (!NRST)
      (WR && ADDR == `IPSE_ADDR_RCAUSE) |=>
        levels_on == $past(WDATA[`IPSE_RC_PRIO_ON]);
  endproperty
  a_prio_on: assert property (p_prio_on)
    else $error("priority enable bit not written");

  property p_pin_wake;
    @(posedge CORE_CLK) disable iff (!NRST)
      (s_reg.pwr == ipse_pkg::IPSE_SLEEP && |(pin_flag & pin_en)) |=> WAKE;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("enabled pin did not wake");
endmodule

/* File: ipse_core_model.sv */
`timescale 1ns/1ps
// Core side of the block: vectors when armed and a request is raised
module ipse_core_model (
  input wire logic clk,
  input wire logic arm,
  input wire logic irq_high,
  input wire logic irq_low,
  output logic take = 1'b0,
  output logic [20:0] pc = 21'h00_0000,
  output ipse_pkg::ipse_ctx_s ctx = 24'h00_0000
);
  // One-cycle take; between takes the values churn, so a late save shows
  always @(posedge clk) begin
    take <= 1'b0;
    pc <= ~pc;
    ctx <= ~ctx;
    if (arm && (irq_high || irq_low) && !take) begin
      take <= 1'b1;
      pc <= 21'($urandom);
      ctx <= 24'($urandom);
    end
  end
endmodule

/* File: interrupt_priority_and_external_irq_test.sv */
`timescale 1ns/1ps
`include "ipse_map.svh"
module interrupt_priority_and_external_irq_test;
  logic clk = 0, nrst_n = 0, wr = 0, rd = 0, slp = 0, dp = 0, arm = 0;
  logic [11:0] addr = 0;
  logic [7:0] wd = 0, rdata, rv;
  logic [3:0] pin = 0;
  logic [7:4] pb = 0;
  logic [15:0] t0 = 0;
  logic [5:0] cs = 0;
  logic [23:0] pf = 0, pe = 0;
  logic ih, il, wk, pv, take, pend = 0, tk_d = 0;
  logic [20:0] pc, spc, pc_d;
  ipse_pkg::ipse_ctx_s ctx, sh, ctx_d;
  logic [7:0] q[$];
  int n_fail = 0, tests_run = 0, wakes = 0, pors = 0;
  // 25 MHz core clock
  always #20 clk = ~clk;
  ipse_ctrl #(.SMALL_PKG(1'b1)) ipse_ctrl_inst (.CORE_CLK(clk),
    .NRST(nrst_n), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd),
    .RDATA(rdata), .EXT_PIN(pin), .PORTB_IN(pb), .T0_COUNT(t0),
    .PERIPH_FLAG(pf), .PERIPH_EN(pe), .SLEEP_REQ(slp), .DEEP_REQ(dp),
    .CAUSE_SET(cs), .TAKE(take), .CORE_PC(pc), .CORE_CTX(ctx),
    .IRQ_HIGH(ih), .IRQ_LOW(il), .WAKE(wk), .POR_VECTOR(pv),
    .STACK_PC(spc), .SHADOW(sh));
  ipse_core_model ipse_core_model_inst (.clk(clk), .arm(arm),
    .irq_high(ih), .irq_low(il), .take(take), .pc(pc), .ctx(ctx));
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus write: one strobe cycle
  task w(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Bus read; expected data queued for the monitor
  task r(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Request lines after the flag and request latency
  task irq(input logic h, input logic l);
    cyc(3);
    chk({ih, il}, {h, l});
  endtask
  // Timer step from a to b, then main control read back
  task tw(input logic [15:0] a, input logic [15:0] b, input logic [7:0] e);
    t0 <= a;
    cyc(2);
    t0 <= b;
    cyc(3);
    r(`IPSE_ADDR_MAIN, e);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Monitor: read data one cycle after the strobe, saves after a take
  always @(posedge clk) begin
    if (pend)
      chk(rdata, q.pop_front());
    if (tk_d) begin
      chk(spc, pc_d);
      chk(sh, ctx_d);
    end
    if (wk === 1'b1)
      wakes++;
    if (pv === 1'b1)
      pors++;
    pend = rd;
    tk_d = take;
    pc_d = pc;
    ctx_d = ctx;
  end
  // Watchdog at 5000 cycles, well beyond the 170 or so cycles of the sequence
  initial begin
    #(40 * 5000);
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h370e));
    cyc(8);
    nrst_n <= 1'b1;
    r(`IPSE_ADDR_PRIO1, 8'h7f);
    r(`IPSE_ADDR_PRIO2, 8'hff);
    r(`IPSE_ADDR_PRIO3, 8'hff);
    r(`IPSE_ADDR_RCAUSE, 8'h3c);
    r(12'h000, 8'h00);
    rv = 8'($urandom);
    w(`IPSE_ADDR_PRIO1, rv & 8'hf7);
    r(`IPSE_ADDR_PRIO1, rv & 8'h77);
    // Single level: peripheral sources need their global enable
    w(`IPSE_ADDR_MAIN, 8'h80);
    pf <= 24'h00_0008;
    pe <= 24'h00_0008;
    irq(0, 0);
    w(`IPSE_ADDR_CORE, 8'h01);
    irq(1, 0);
    // Levels on; the source's low priority bit now counts
    w(`IPSE_ADDR_RCAUSE, 8'hff);
    r(`IPSE_ADDR_RCAUSE, 8'hbf);
    irq(0, 0);
    w(`IPSE_ADDR_MAIN, 8'hc0);
    irq(0, 1);
    r(`IPSE_ADDR_FLAGS, 8'h02);
    arm <= 1'b1;
    cyc(2);
    arm <= 0;
    pe <= 0;
    irq(0, 0);
    pf <= 0;
    // Pin 1 on both edge polarities
    for (int e = 0; e < 2; e++) begin
      w(`IPSE_ADDR_CTL2, e ? 8'h20 : 8'h00);
      pin[1] <= ~e[0];
      w(`IPSE_ADDR_CTL3, 8'h00);
      pin[1] <= e[0];
      irq(0, 0);
      r(`IPSE_ADDR_CTL3, 8'h01);
      w(`IPSE_ADDR_CTL3, 8'h09);
      irq(0, 1);
      w(`IPSE_ADDR_CTL3, 8'h49);
      irq(1, 0);
    end
    w(`IPSE_ADDR_CTL3, 8'h00);
    // Pin 0 has no priority bit
    w(`IPSE_ADDR_CTL2, 8'h40);
    w(`IPSE_ADDR_MAIN, 8'hd0);
    pin[0] <= 1'b1;
    irq(1, 0);
    w(`IPSE_ADDR_MAIN, 8'h00);
    tw(16'h00ff, 16'h0000, 8'h04);
    w(`IPSE_ADDR_MAIN, 8'h00);
    w(`IPSE_ADDR_CORE, 8'h03);
    tw(16'h00ff, 16'h0100, 8'h00);
    tw(16'hffff, 16'h0000, 8'h04);
    w(`IPSE_ADDR_MAIN, 8'he4);
    irq(0, 1);
    w(`IPSE_ADDR_MAIN, 8'h00);
    pb <= 4'($urandom_range(15, 1));
    cyc(3);
    r(`IPSE_ADDR_MAIN, 8'h01);
    w(`IPSE_ADDR_MAIN, 8'hc9);
    irq(0, 1);
    // Wake from Sleep, then from Deep Sleep, on a pin 0 edge
    w(`IPSE_ADDR_MAIN, 8'h10);
    slp <= 1'b1;
    cyc(1);
    slp <= 0;
    pin[0] <= 0;
    cyc(1);
    pin[0] <= 1'b1;
    cyc(4);
    chk(wakes, 1);
    w(`IPSE_ADDR_MAIN, 8'h10);
    dp <= 1'b1;
    cyc(1);
    dp <= 0;
    pin[0] <= 0;
    cyc(1);
    pin[0] <= 1'b1;
    cyc(4);
    chk(pors, 1);
    // Reset in mid-run with pins and port B high: no false events
    nrst_n <= 1'b0;
    cyc(2);
    nrst_n <= 1'b1;
    cyc(1);
    r(`IPSE_ADDR_MAIN, 8'h00);
    r(`IPSE_ADDR_CTL3, 8'hc0);
    // Cause pulses OR into the flags; power flags ignore writes
    rv = 8'($urandom);
    cs <= rv[5:0];
    cyc(1);
    cs <= 6'h00;
    r(`IPSE_ADDR_RCAUSE, 8'h3c | (rv & 8'h3f));
    w(`IPSE_ADDR_RCAUSE, 8'h00);
    r(`IPSE_ADDR_RCAUSE, 8'h0c);
    wrap_up();
  end
endmodule
